/* char_lcd_instruction_decoder.sv */
// Instruction decoder and execution control of a character display
//
// Contract
// - Clear fills spaces, zeroes counter, sets increment
// - Home zeroes counter and display shift
// - Direction flag picks increment or decrement
// - Pattern memory accesses step the counter too
// - Shift-enabled display writes shift whole display
// - Display bit blanks without losing memory
// - Cursor bit hides cursor, keeps direction
// - Blink alternates cursor cell every 185 ms
// - Shift instruction moves cursor or display
// - Display shift keeps the address counter
// - Two-line cursor wraps past 27h to 40h
// - Width bit selects byte or nibble pairs
// - Line and font bits pick duty
// - Pattern address set loads six bits
// - Display address set loads seven bits
// - Status read gives busy and counter
// - Data access targets selected memory, 18.5 us
// - Instructions ignored while busy
// - Nibble mode sends upper nibble first
// - Two-line lines at 00h-27h and 40h-67h
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`include "lcd_map.svh"
`default_nettype none
module char_lcd_instruction_decoder
   import lcd_pkg::*;
#(
   parameter int CLEAR_CYCLES =
      (`LCD_T_CLEAR_NS + `LCD_CLK_PERIOD_NS - 1) / `LCD_CLK_PERIOD_NS,
   parameter int BLINK_CYCLES =
      (`LCD_T_BLINK_MS * 1000000) / `LCD_CLK_PERIOD_NS
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic busy_flag,
   output logic display_on,
   output logic cursor_on,
   output logic blink_on,
   output logic blink_phase,
   output logic bus_width_sel,
   output logic two_line,
   output logic font_tall,
   output duty_t duty,
   output logic [6:0] display_shift
);
   localparam int EXEC_CYCLES =
      (`LCD_T_EXEC_NS + `LCD_CLK_PERIOD_NS - 1) / `LCD_CLK_PERIOD_NS;
   localparam int TW = $clog2(BLINK_CYCLES + CLEAR_CYCLES + 1) + 1;

   generate
      if (CLEAR_CYCLES < 1 || BLINK_CYCLES < 2) begin : g_bad
         $error("Clear and blink cycle counts must be positive");
      end
   endgenerate

   function automatic op_t decode(input logic [7:0] b);
      op_t r;
      r = OP_NONE;
      if (b[7]) r = OP_DDADDR;
      else if (b[6]) r = OP_CGADDR;
      else if (b[5]) r = OP_FUNC;
      else if (b[4]) r = OP_SHIFT;
      else if (b[3]) r = OP_DISPLAY;
      else if (b[2]) r = OP_ENTRY;
      else if (b[1]) r = OP_HOME;
      else if (b[0]) r = OP_CLEAR;
      return r;
   endfunction : decode

   // Next counter value, wrapping per memory and line layout
   function automatic logic [6:0] ac_step(input logic [6:0] a,
         input logic up, input logic two, input logic cg);
      logic [6:0] r;
      r = up ? a + 7'h01 : a - 7'h01;
      if (cg) begin
         r = {1'b0, r[5:0]};
      end else if (two) begin
         if (up && a == `LCD_LINE1_END) r = `LCD_LINE2_BASE;
         else if (up && a == `LCD_LINE2_END) r = 7'h00;
         else if (!up && a == `LCD_LINE2_BASE) r = `LCD_LINE1_END;
         else if (!up && a == 7'h00) r = `LCD_LINE2_END;
      end else begin
         if (up && a == `LCD_ONE_END) r = 7'h00;
         else if (!up && a == 7'h00) r = `LCD_ONE_END;
      end
      return r;
   endfunction : ac_step

   // Display shift offset, modulo the line length
   function automatic logic [6:0] off_step(input logic [6:0] o,
         input logic left, input logic two);
      logic [6:0] span;
      span = two ? `LCD_LINE_LEN : `LCD_ONE_LEN;
      if (left) return (o >= span - 7'h01) ? 7'h00 : o + 7'h01;
      return (o == 7'h00 || o >= span) ? span - 7'h01 : o - 7'h01;
   endfunction : off_step

   store_if mem_if ();
   logic [6:0] ac;
   logic cg_sel, inc_dir, shift_en, font_bit;
   logic ack, req, accept;
   logic sel_instr, sel_data, sel_mode;
   logic wr_half, rd_half;
   logic [3:0] nib_hold;
   logic [7:0] byte_wr;
   logic full_wr, full_rd;
   logic go_instr, go_wdata, go_rdata;
   logic busy_start;
   logic [TW-1:0] busy_load;
   logic blink_active;
   logic [7:0] read_byte;
   logic [31:0] mode_word;
   op_t op;

   // Bus handshake: one wait state per request
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack;
   assign accept = req & ack;
   assign sel_instr = (avs_address == `LCD_REG_INSTR);
   assign sel_data = (avs_address == `LCD_REG_DATA);
   assign sel_mode = (avs_address == `LCD_REG_MODE);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   // Nibble pairing, upper half first
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_half <= 1'b0;
         rd_half <= 1'b0;
         nib_hold <= 4'h0;
      end else if (bus_width_sel) begin
         wr_half <= 1'b0;
         rd_half <= 1'b0;
      end else if (accept && (sel_instr || sel_data)) begin
         if (avs_write) begin
            wr_half <= ~wr_half;
            if (!wr_half) nib_hold <= avs_writedata[3:0];
         end else begin
            rd_half <= ~rd_half;
         end
      end
   end

   assign byte_wr = bus_width_sel ? avs_writedata[7:0] :
      {nib_hold, avs_writedata[3:0]};
   assign full_wr = accept & avs_write & (sel_instr | sel_data) &
      (bus_width_sel | wr_half);
   assign full_rd = accept & avs_read & sel_data & (bus_width_sel | rd_half);
   assign go_instr = full_wr & sel_instr & ~busy_flag;
   assign go_wdata = full_wr & sel_data & ~busy_flag;
   assign go_rdata = full_rd & ~busy_flag;
   assign op = decode(byte_wr);

   // Busy timing per instruction class
   assign busy_start = (go_instr && op != OP_NONE) || go_wdata || go_rdata;
   assign busy_load = (go_instr && (op == OP_CLEAR || op == OP_HOME)) ?
      TW'(CLEAR_CYCLES) : TW'(EXEC_CYCLES);

   cycle_timer #(.W(TW)) busy_timer (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .start(busy_start),
      .load(busy_load),
      .active(busy_flag)
   );

   // Blink half-period timer, restarted on each expiry
   cycle_timer #(.W(TW)) blink_timer (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .start(~blink_active),
      .load(TW'(BLINK_CYCLES - 1)),
      .active(blink_active)
   );

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         blink_phase <= 1'b0;
      end else if (!blink_on) begin
         blink_phase <= 1'b0;
      end else if (!blink_active) begin
         blink_phase <= ~blink_phase;
      end
   end

   assign mem_if.we = go_wdata;
   assign mem_if.clear = go_instr && op == OP_CLEAR;
   assign mem_if.cg_sel = cg_sel;
   assign mem_if.two_line = two_line;
   assign mem_if.addr = ac;
   assign mem_if.wdata = byte_wr;

   char_store store (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .port(mem_if.mem)
   );

   // Address counter and memory select
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ac <= 7'h00;
         cg_sel <= 1'b0;
      end else if (go_instr) begin
         case (op)
            OP_CLEAR, OP_HOME: begin
               ac <= 7'h00;
            end
            OP_CGADDR: begin
               ac <= {1'b0, byte_wr[5:0]};
               cg_sel <= 1'b1;
            end
            OP_DDADDR: begin
               ac <= byte_wr[6:0];
               cg_sel <= 1'b0;
            end
            OP_SHIFT: begin
               if (!byte_wr[`LCD_BIT_SC]) begin
                  ac <= ac_step(ac, byte_wr[`LCD_BIT_RL], two_line, cg_sel);
               end
            end
            default: begin
            end
         endcase
      end else if (go_wdata || go_rdata) begin
         ac <= ac_step(ac, inc_dir, two_line, cg_sel);
      end
   end

   // Display shift offset, counter left alone
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         display_shift <= 7'h00;
      end else if (go_instr && (op == OP_CLEAR || op == OP_HOME)) begin
         display_shift <= 7'h00;
      end else if (go_instr && op == OP_SHIFT && byte_wr[`LCD_BIT_SC]) begin
         display_shift <= off_step(display_shift,
            ~byte_wr[`LCD_BIT_RL], two_line);
      end else if (go_wdata && !cg_sel && shift_en) begin
         display_shift <= off_step(display_shift, inc_dir, two_line);
      end
   end

   // Entry mode bits
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         inc_dir <= `LCD_RST_ID;
         shift_en <= `LCD_RST_SHIFT_EN;
      end else if (go_instr && op == OP_CLEAR) begin
         inc_dir <= 1'b1;
      end else if (go_instr && op == OP_ENTRY) begin
         inc_dir <= byte_wr[`LCD_BIT_ID];
         shift_en <= byte_wr[`LCD_BIT_S];
      end
   end

   // Display control bits
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         display_on <= `LCD_RST_DISP;
         cursor_on <= `LCD_RST_CURSOR;
         blink_on <= `LCD_RST_BLINK;
      end else if (go_instr && op == OP_DISPLAY) begin
         display_on <= byte_wr[`LCD_BIT_D];
         cursor_on <= byte_wr[`LCD_BIT_C];
         blink_on <= byte_wr[`LCD_BIT_B];
      end
   end

   // Function set bits
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bus_width_sel <= `LCD_RST_BUS_WIDTH;
         two_line <= `LCD_RST_TWO_LINE;
         font_bit <= `LCD_RST_FONT;
      end else if (go_instr && op == OP_FUNC) begin
         bus_width_sel <= byte_wr[`LCD_BIT_DL];
         two_line <= byte_wr[`LCD_BIT_N];
         font_bit <= byte_wr[`LCD_BIT_F];
      end
   end

   assign font_tall = ~two_line & font_bit;
   assign duty = two_line ? DUTY_16 : (font_bit ? DUTY_11 : DUTY_8);

   // Read answers, captured as the request is first seen
   assign read_byte = sel_instr ? {busy_flag, ac} : mem_if.rdata;
   assign mode_word = {9'h000, display_shift, 5'h00, busy_flag,
      blink_phase, cg_sel, font_bit, two_line, bus_width_sel,
      shift_en, inc_dir, blink_on, cursor_on, display_on};

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack) begin
         if (sel_mode) begin
            avs_readdata <= mode_word;
         end else if (!(sel_instr || sel_data)) begin
            avs_readdata <= 32'h0000_0000;
         end else if (bus_width_sel) begin
            avs_readdata <= {24'h00_0000, read_byte};
         end else if (rd_half) begin
            avs_readdata <= {28'h000_0000, read_byte[3:0]};
         end else begin
            avs_readdata <= {28'h000_0000, read_byte[7:4]};
         end
      end
   end

   AST_CLEAR: assert property (@(posedge clk_sys)
      disable iff (!arst_n) go_instr && op == OP_CLEAR |=> ac == 7'h00
      && inc_dir && busy_flag && display_shift == 7'h00)
      else $error("Clear did not reset counter and direction");
   AST_HOME: assert property (@(posedge clk_sys)
      disable iff (!arst_n) go_instr && op == OP_HOME |=> ac == 7'h00
      && display_shift == 7'h00 && $stable(inc_dir))
      else $error("Return home failed");
   AST_EXEC_BUSY: assert property (@(posedge clk_sys)
      disable iff (!arst_n) go_wdata |=> busy_flag [*8])
      else $error("Busy dropped too early after data access");
   AST_BUSY_IGNORE: assert property (@(posedge clk_sys)
      disable iff (!arst_n) full_wr && sel_instr && busy_flag
      |=> $stable({inc_dir, shift_en, display_on, cursor_on, blink_on,
      two_line, font_bit, ac}))
      else $error("Instruction taken while busy");
   AST_DD_ADDR: assert property (@(posedge clk_sys)
      disable iff (!arst_n) go_instr && op == OP_DDADDR
      |=> ac == $past(byte_wr[6:0]) && !cg_sel)
      else $error("Display address set wrong");
   AST_CG_ADDR: assert property (@(posedge clk_sys)
      disable iff (!arst_n) go_instr && op == OP_CGADDR
      |=> ac == {1'b0, $past(byte_wr[5:0])} && cg_sel)
      else $error("Pattern address set wrong");
   AST_SHIFT_KEEPS_AC: assert property (@(posedge clk_sys)
      disable iff (!arst_n) go_instr && op == OP_SHIFT
      && byte_wr[`LCD_BIT_SC] |=> $stable(ac))
      else $error("Display shift moved the counter");
   AST_LINE_WRAP: assert property (@(posedge clk_sys)
      disable iff (!arst_n) go_wdata && two_line && !cg_sel && inc_dir
      && ac == `LCD_LINE1_END |=> ac == `LCD_LINE2_BASE)
      else $error("Two-line wrap missed second line");
   AST_STATUS_READ: assert property (@(posedge clk_sys)
      disable iff (!arst_n) avs_read && !ack && sel_instr && bus_width_sel
      |=> avs_readdata[6:0] == $past(ac)
      && avs_readdata[7] == $past(busy_flag))
      else $error("Status read wrong");
   AST_DUTY: assert property (@(posedge clk_sys)
      disable iff (!arst_n) two_line |-> duty == DUTY_16 && !font_tall)
      else $error("Two-line duty wrong");
endmodule : char_lcd_instruction_decoder
`default_nettype wire

/* lcd_map.svh */
// Offsets, field positions, reset values and timing figures of the decoder
`ifndef LCD_MAP_SVH
`define LCD_MAP_SVH
`define LCD_REG_INSTR 4'h0
`define LCD_REG_DATA 4'h4
`define LCD_REG_MODE 4'h8
`define LCD_CLK_PERIOD_NS 10
`define LCD_T_EXEC_NS 18500
`define LCD_T_CLEAR_NS 760000
`define LCD_T_BLINK_MS 185
`define LCD_SPACE_CODE 8'h20
`define LCD_LINE1_END 7'h27
`define LCD_LINE2_BASE 7'h40
`define LCD_LINE2_END 7'h67
`define LCD_ONE_END 7'h4F
`define LCD_LINE2_SKIP 7'h18
`define LCD_LINE_LEN 7'h28
`define LCD_ONE_LEN 7'h50
`define LCD_DD_DEPTH 80
`define LCD_CG_DEPTH 64
`define LCD_BIT_ID 1
`define LCD_BIT_S 0
`define LCD_BIT_D 2
`define LCD_BIT_C 1
`define LCD_BIT_B 0
`define LCD_BIT_SC 3
`define LCD_BIT_RL 2
`define LCD_BIT_DL 4
`define LCD_BIT_N 3
`define LCD_BIT_F 2
`define LCD_MODE_SHIFT_POS 16
`define LCD_RST_ID 1'b1
`define LCD_RST_SHIFT_EN 1'b0
`define LCD_RST_DISP 1'b0
`define LCD_RST_CURSOR 1'b0
`define LCD_RST_BLINK 1'b0
`define LCD_RST_BUS_WIDTH 1'b1
`define LCD_RST_TWO_LINE 1'b0
`define LCD_RST_FONT 1'b0
`endif

/* lcd_pkg.sv */
// Types shared by the display instruction decoder
`default_nettype none
package lcd_pkg;
   typedef enum logic [3:0] {
      OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISPLAY,
      OP_SHIFT, OP_FUNC, OP_CGADDR, OP_DDADDR
   } op_t;
   typedef enum logic [1:0] {DUTY_8, DUTY_11, DUTY_16} duty_t;
endpackage : lcd_pkg
`default_nettype wire

/* store_if.sv */
// Link between the decoder and its character memories
`default_nettype none
interface store_if;
   logic we;
   logic clear;
   logic cg_sel;
   logic two_line;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctl(output we, clear, cg_sel, two_line, addr, wdata,
      input rdata);
   modport mem(input we, clear, cg_sel, two_line, addr, wdata,
      output rdata);
endinterface : store_if
`default_nettype wire

/* cycle_timer.sv */
// Loadable down counter, active while nonzero
`default_nettype none
module cycle_timer #(
   parameter int W = 16
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic start,
   input wire logic [W-1:0] load,
   output logic active
);
   logic [W-1:0] count;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         count <= '0;
      end else if (start) begin
         count <= load;
      end else if (count != '0) begin
         count <= count - W'(1);
      end
   end

   assign active = (count != '0);
endmodule : cycle_timer
`default_nettype wire

/* char_store.sv */
// Display and pattern memories held in flip-flops
`include "lcd_map.svh"
`default_nettype none
module char_store (
   input wire logic clk_sys,
   input wire logic arst_n,
   store_if.mem port
);
   logic [7:0] dd [`LCD_DD_DEPTH];
   logic [7:0] cg [`LCD_CG_DEPTH];
   logic [6:0] dd_idx;
   logic dd_ok;

   // Second line 40h..67h packs behind the first line
   always_comb begin
      dd_idx = port.addr;
      if (port.two_line && port.addr[6]) begin
         dd_idx = port.addr - `LCD_LINE2_SKIP;
      end
      dd_ok = (dd_idx < `LCD_ONE_LEN);
      // Gap after the first of two lines holds no cells
      if (port.two_line && !port.addr[6] && port.addr > `LCD_LINE1_END) begin
         dd_ok = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `LCD_DD_DEPTH; i++) dd[i] <= `LCD_SPACE_CODE;
      end else if (port.clear) begin
         for (int i = 0; i < `LCD_DD_DEPTH; i++) dd[i] <= `LCD_SPACE_CODE;
      end else if (port.we && !port.cg_sel && dd_ok) begin
         dd[dd_idx] <= port.wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `LCD_CG_DEPTH; i++) cg[i] <= 8'h00;
      end else if (port.we && port.cg_sel) begin
         cg[port.addr[5:0]] <= port.wdata;
      end
   end

   always_comb begin
      if (port.cg_sel) begin
         port.rdata = cg[port.addr[5:0]];
      end else if (dd_ok) begin
         port.rdata = dd[dd_idx];
      end else begin
         port.rdata = 8'h00;
      end
   end
endmodule : char_store
`default_nettype wire

/* host_model.sv */
// Host processor model on the decoder's register bus
`default_nettype none
module host_model (
   input wire logic clk_sys,
   output logic [3:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   logic nib = 1'b0; // Byte transfers unless set otherwise
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end
   task automatic cycle(input logic [3:0] a, input logic w,
      input logic [7:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= ~w;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk_sys);
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= ~avs_writedata;
   endtask : cycle
   task automatic put(input logic [3:0] a, input logic [7:0] b);
      logic [31:0] q;
      if (nib) begin
         cycle(a, 1'b1, {4'h0, b[7:4]}, q);
         cycle(a, 1'b1, {4'h0, b[3:0]}, q);
      end else begin
         cycle(a, 1'b1, b, q);
      end
   endtask : put
   task automatic get(input logic [3:0] a, output logic [7:0] b);
      logic [31:0] q;
      cycle(a, 1'b0, 8'h00, q);
      b = q[7:0];
      if (nib) begin
         b[7:4] = q[3:0];
         cycle(a, 1'b0, 8'h00, q);
         b[3:0] = q[3:0];
      end
   endtask : get
   task automatic poll();
      logic [7:0] s;
      get(4'h0, s);
      while (s[7] !== 1'b0) begin
         get(4'h0, s);
      end
   endtask : poll
   task automatic instr(input logic [7:0] b);
      put(4'h0, b);
      if (b[7:5] == 3'b001) begin
         nib = ~b[4];
      end
      poll();
   endtask : instr
endmodule : host_model
`default_nettype wire

/* tb_top.sv */
// Self-checking testbench of the display instruction decoder
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   n_fail++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top
   import lcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] avs_address;
   logic avs_read, avs_write, avs_waitrequest, busy_flag;
   logic [31:0] avs_writedata, avs_readdata;
   logic display_on, cursor_on, blink_on, blink_phase;
   logic bus_width_sel, two_line, font_tall;
   duty_t duty;
   logic [6:0] display_shift;
   int n_fail = 0;
   int n_compared = 0;
   int cycles = 0;
   always #5 clk_sys = ~clk_sys;
   char_lcd_instruction_decoder #(.CLEAR_CYCLES(20), .BLINK_CYCLES(8))
   char_lcd_instruction_decoder_inst (.clk_sys(clk_sys), .arst_n(arst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .busy_flag(busy_flag), .display_on(display_on),
      .cursor_on(cursor_on), .blink_on(blink_on),
      .blink_phase(blink_phase), .bus_width_sel(bus_width_sel),
      .two_line(two_line), .font_tall(font_tall), .duty(duty),
      .display_shift(display_shift));
   host_model host_model_inst (.clk_sys(clk_sys),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   task automatic wrap_up();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 95000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic ins(input logic [7:0] b);
      host_model_inst.instr(b);
   endtask : ins
   task automatic dat(input logic [7:0] b);
      host_model_inst.put(4'h4, b);
      host_model_inst.poll();
   endtask : dat
   task automatic rdd(output logic [7:0] b);
      host_model_inst.get(4'h4, b);
      host_model_inst.poll();
   endtask : rdd
   task automatic ac(output logic [7:0] s);
      host_model_inst.get(4'h0, s);
   endtask : ac
   task automatic mode(output logic [31:0] m);
      host_model_inst.cycle(4'h8, 1'b0, 8'h00, m);
   endtask : mode
   task automatic t_reset();
      logic [31:0] m;
      mode(m);
      `CHK("mode", 32'h0000_0028, m)
      host_model_inst.cycle(4'hC, 1'b0, 8'h00, m);
      `CHK("unmapped", 32'h0, m)
      `CHK("duty", DUTY_8, duty)
      `CHK("idle", 1'b0, busy_flag)
   endtask : t_reset
   task automatic t_data();
      logic [7:0] s;
      ins(8'h85);
      host_model_inst.put(4'h4, 8'h41);
      // Address set while busy must be dropped
      host_model_inst.put(4'h0, 8'h90);
      ac(s);
      `CHK("busy_ac", 8'h86, s)
      `CHK("busy_pin", 1'b1, busy_flag)
      host_model_inst.poll();
      host_model_inst.put(4'h0, 8'h00);
      ac(s);
      `CHK("nop", 8'h06, s)
      ins(8'h85);
      rdd(s);
      `CHK("data", 8'h41, s)
      ac(s);
      `CHK("ac_inc", 8'h06, s)
   endtask : t_data
   task automatic t_entry_clear();
      logic [7:0] s;
      logic [31:0] m;
      ins(8'h04);
      dat(8'h42);
      ac(s);
      `CHK("ac_dec", 8'h05, s)
      ins(8'h01);
      ac(s);
      `CHK("clr_ac", 8'h00, s)
      mode(m);
      `CHK("clr_dir", 1'b1, m[3])
      ins(8'h85);
      rdd(s);
      `CHK("clr_mem", 8'h20, s)
   endtask : t_entry_clear
   task automatic t_pattern_memory();
      logic [7:0] s;
      logic [31:0] m;
      ins(8'h07);
      ins(8'h43);
      dat(8'h1F);
      ac(s);
      `CHK("cg_ac", 8'h04, s)
      `CHK("cg_noshift", 7'h00, display_shift)
      mode(m);
      `CHK("cg_sel", 1'b1, m[8])
      ins(8'h43);
      rdd(s);
      `CHK("cg_data", 8'h1F, s)
      ins(8'h80);
      dat(8'h55);
      `CHK("shl", 7'h01, display_shift)
      ins(8'h05);
      dat(8'h56);
      `CHK("shr", 7'h00, display_shift)
      ins(8'h06);
   endtask : t_pattern_memory
   task automatic t_shift();
      logic [7:0] c [4] = '{8'h10, 8'h14, 8'h18, 8'h1C};
      logic [7:0] ea [4] = '{8'h0F, 8'h10, 8'h10, 8'h10};
      logic [6:0] es [4] = '{7'h00, 7'h00, 7'h01, 7'h00};
      logic [7:0] s;
      ins(8'h90);
      for (int i = 0; i < 4; i++) begin
         ins(c[i]);
         ac(s);
         `CHK("sh_ac", ea[i], s)
         `CHK("sh_pos", es[i], display_shift)
      end
   endtask : t_shift
   task automatic t_home();
      logic [7:0] s;
      ins(8'h18);
      ins(8'h03);
      ac(s);
      `CHK("home_ac", 8'h00, s)
      `CHK("home_pos", 7'h00, display_shift)
      ins(8'h80);
      rdd(s);
      `CHK("home_mem", 8'h55, s)
   endtask : t_home
   task automatic t_two_line();
      logic [7:0] c [4] = '{8'h30, 8'h34, 8'h38, 8'h3C};
      duty_t ed [4] = '{DUTY_8, DUTY_11, DUTY_16, DUTY_16};
      logic ef [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
      logic [7:0] s;
      for (int i = 0; i < 4; i++) begin
         ins(c[i]);
         `CHK("duty", ed[i], duty)
         `CHK("font", ef[i], font_tall)
      end
      `CHK("two_line", 1'b1, two_line)
      ins(8'hA7);
      ins(8'h14);
      ac(s);
      `CHK("wrap", 8'h40, s)
      ins(8'h10);
      ac(s);
      `CHK("back", 8'h27, s)
      dat(8'h33);
      ac(s);
      `CHK("wrap_wr", 8'h40, s)
   endtask : t_two_line
   task automatic t_display();
      logic [7:0] s;
      logic [31:0] m;
      logic b;
      ins(8'h0F);
      `CHK("dcb", 3'b111, {display_on, cursor_on, blink_on})
      @(posedge clk_sys);
      b = blink_phase;
      repeat (8) @(posedge clk_sys);
      `CHK("blink", ~b, blink_phase)
      ins(8'h04);
      ins(8'h0D);
      `CHK("cursor", 1'b0, cursor_on)
      mode(m);
      `CHK("keep_dir", 1'b0, m[3])
      ins(8'h08);
      `CHK("disp_off", 1'b0, display_on)
      `CHK("blink_off", 1'b0, blink_phase)
      ins(8'h80);
      rdd(s);
      `CHK("kept", 8'h55, s)
   endtask : t_display
   task automatic t_nibble();
      logic [7:0] s;
      ins(8'h28);
      `CHK("width4", 1'b0, bus_width_sel)
      ins(8'hC5);
      ac(s);
      `CHK("nib_ac", 8'h45, s)
      ins(8'h38);
      `CHK("width8", 1'b1, bus_width_sel)
      ac(s);
      `CHK("byte_ac", 8'h45, s)
   endtask : t_nibble
   initial begin
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_reset();
      t_data();
      t_entry_clear();
      t_pattern_memory();
      t_shift();
      t_home();
      t_two_line();
      t_display();
      t_nibble();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
